//--- dv/pa_pin_model.sv
// External pin circuitry model for the port A pin block
module pa_pin_model (
  input wire pa_pkg::pa_pad_t i_pad,
  input wire logic [5:0] i_ext,
  input wire logic [5:0] i_mid,
  output logic [5:0] o_st,
  output logic [5:0] o_ttl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pin levels
  // Driven pins show the pad; a mid-rail level splits the two thresholds
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      o_st[i] = i_pad.oe[i] ? i_pad.out[i] : (i_mid[i] ? 1'b0 : i_ext[i]);
      o_ttl[i] = i_pad.oe[i] ? i_pad.out[i] : (i_mid[i] ? 1'b1 : i_ext[i]);
    end
  end
endmodule : pa_pin_model

//--- dv/tb.sv
// Self-checking testbench for the port A pin block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and reference state
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [5:0] pin_st;
  logic [5:0] pin_ttl;
  logic pin_c3 = 1'b0;
  pa_pkg::pa_periph_t per = '0;
  pa_pkg::pa_pad_t pad;
  logic t1g;
  logic cc1;
  logic cc2;
  logic cc1_14;
  logic cc2_14;
  logic [5:0] pdig;
  pa_pkg::pa_pad_t pad14;
  pa_pkg::pa_src_t c3s;
  logic [31:0] prdata14;
  logic [5:0] ext = 6'h00;
  logic [5:0] mid = 6'h00;
  logic [7:0] dir_m, lat_m, odr_m, ana_m, thr_m, slw_m, str_m;
  logic [31:0] seed = 32'h0000E00E;
  logic [31:0] rd;
  logic [31:0] rd14;
  logic [31:0] r;
  logic [7:0] v;
  logic er;
  int errors = 0;
  int cmp_count = 0;

  // Clock generation
  always #12.5 clk_sys = ~clk_sys;

  pa_port_top u_dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hF), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_pin_st(pin_st), .i_pin_ttl(pin_ttl), .i_pin_c3(pin_c3), .i_periph(per),
    .o_pad(pad), .o_c3_src(), .o_pin_digital(pdig), .o_timer1_gate_in(t1g),
    .o_capcmp1_in(cc1), .o_capcmp2_in(cc2));

  // 14-pin variant on the same bus; its pin inputs follow the 8-pin pads
  pa_port_top #(.p_eight_pin(1'b0)) u_dut14 (.i_clk_sys(clk_sys), .i_arst_n(arst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(), .o_prdata(prdata14), .o_pslverr(),
    .i_pin_st(pin_st), .i_pin_ttl(pin_ttl), .i_pin_c3(pin_c3), .i_periph(per),
    .o_pad(pad14), .o_c3_src(c3s), .o_pin_digital(), .o_timer1_gate_in(),
    .o_capcmp1_in(cc1_14), .o_capcmp2_in(cc2_14));

  pa_pin_model u_pins (.i_pad(pad), .i_ext(ext), .i_mid(mid), .o_st(pin_st),
    .o_ttl(pin_ttl));

  // ==========================================================================
  // Reference functions
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Enabled source takes the pin with its own drive request
  function automatic logic [1:0] ov(pa_pkg::pa_src_t s, logic ok, logic [1:0] q);
    return (ok && s.en) ? {s.drv, s.val} : q;
  endfunction : ov

  // Expected {drive, level} of one pad; e8 picks the 8-pin priority tables
  function automatic logic [1:0] pin_exp(int i, logic e8);
    logic [1:0] q;
    q = {1'b0, lat_m[i]};
    case (i)
      0: q = ov(per.dac, 1'b1, ov(per.wg_b, e8 & ~str_m[5], ov(per.capcmp_unit_2, e8, q)));
      1: q = ov(per.zcd, 1'b1, q);
      2:
      begin
        q = ov(per.capcmp_unit_1, e8 & ~str_m[0], q);
        q = ov(per.wg_a, e8 & ~str_m[6], ov(per.cmp1, 1'b1, q));
      end
      4: q = ov(per.clock_output_pin_fn, 1'b1, ov(per.wg_b, e8 & str_m[5], q));
      5:
      begin
        q = ov(per.capcmp_unit_2, ~e8 & str_m[1], q);
        q = ov(per.wg_a, e8 & str_m[6], ov(per.capcmp_unit_1, e8 & str_m[0], q));
      end
      default: q = 2'h0;
    endcase
    if (i != 3)
      q[1] = q[1] | ~dir_m[i];
    if (odr_m[i])
      q = {q[1] & ~q[0], 1'b0};
    return q;
  endfunction : pin_exp

  // Expected value register read
  function automatic logic [7:0] val_exp();
    logic [1:0] e;
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      e = pin_exp(i, 1'b1);
      x[i] = e[1] ? e[0] : (mid[i] ? ~thr_m[i] : ext[i]);
    end
    return x & ~ana_m;
  endfunction : val_exp

  // ==========================================================================
  // Checking and bus tasks
  task automatic check(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // One APB transfer, entered just after a rising edge
  task automatic apb(logic wr, logic [7:0] a, logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      complete_run();
    end
    rd = prdata;
    rd14 = prdata14;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(logic [7:0] a, logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(logic [7:0] a, logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask : rdc

  task automatic load();
    wr(pa_pkg::ADDR_THRESH, thr_m);
    wr(pa_pkg::ADDR_DIR, dir_m);
    wr(pa_pkg::ADDR_ODRAIN, odr_m);
    wr(pa_pkg::ADDR_SLEW, slw_m);
    wr(pa_pkg::ADDR_ANALOG, ana_m);
    wr(pa_pkg::ADDR_STEER, str_m);
    repeat (6) @(posedge clk_sys);
  endtask : load

  // Pads against the reference
  task automatic chk_pads(logic e8, pa_pkg::pa_pad_t p);
    logic [1:0] e;
    logic [5:0] eo;
    logic [5:0] ev;
    for (int i = 0; i < 6; i++)
    begin
      e = pin_exp(i, e8);
      eo[i] = e[1];
      ev[i] = e[0] & e[1];
    end
    check(32'(p.oe), 32'(eo));
    check(32'(p.out & eo), 32'(ev));
    check(32'(p.slew), 32'(slw_m[5:0]));
    check(32'(p.schmitt), 32'(thr_m[5:0]));
    check(32'(p.analog), 32'(ana_m[5:0]));
  endtask : chk_pads

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(pa_pkg::ADDR_DIR, 8'h3F);
    rdc(pa_pkg::ADDR_LATCH, 8'h00);
    rdc(pa_pkg::ADDR_ODRAIN, 8'h00);
    rdc(pa_pkg::ADDR_SLEW, 8'h37);
    rdc(pa_pkg::ADDR_THRESH, 8'h00);
    rdc(pa_pkg::ADDR_ANALOG, 8'h17);
    rdc(pa_pkg::ADDR_STEER, 8'h00);
    check(32'(pad.analog), 32'h17);
    apb(1'b0, 8'h24, 8'h00);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'h06, 8'h00);
    check({31'h0, er}, 32'h1);
    wr(pa_pkg::ADDR_DIR, 8'h00);
    rdc(pa_pkg::ADDR_DIR, 8'h08);
    wr(pa_pkg::ADDR_STEER, 8'hFF);
    rdc(pa_pkg::ADDR_STEER, 8'h69);
    check(rd14, 32'h0000000A);
    // Random configurations with peripheral traffic
    for (int k = 0; k < 30; k++)
    begin
      r = rnd();
      per <= '0;
      dir_m = {2'h0, r[5:0]};
      odr_m = (k < 10) ? 8'h00 : {2'h0, r[13:8]} & 8'h37;
      thr_m = {2'h0, r[21:16]};
      slw_m = {2'h0, r[29:24]} & 8'h37;
      ana_m = k[0] ? {3'h0, r[20:16]} & 8'h17 : 8'h00;
      str_m = r[31:24];
      load();
      r = rnd();
      lat_m = {2'h0, r[29:24]} & 8'h37;
      wr(k[1] ? pa_pkg::ADDR_VALUE : pa_pkg::ADDR_LATCH, {2'h0, r[29:24]});
      per <= pa_pkg::pa_periph_t'(r[23:0]);
      ext <= r[5:0] ^ r[29:24];
      mid <= r[11:6] & r[17:12];
      pin_c3 <= r[30];
      repeat (6) @(posedge clk_sys);
      chk_pads(1'b1, pad);
      chk_pads(1'b0, pad14);
      // Steered inputs of both variants except the 14-pin timer1 gate, digital inputs of the 8-pin variant
      v = val_exp();
      check(32'(pdig), 32'(v[5:0]));
      check({31'h0, t1g}, {31'h0, str_m[3] ? v[3] : v[4]});
      check({31'h0, cc1}, {31'h0, str_m[0] ? v[5] : v[2]});
      check({31'h0, cc2}, {31'h0, v[0]});
      check({31'h0, cc1_14}, {31'h0, v[2]});
      check({31'h0, cc2_14}, {31'h0, str_m[1] ? v[5] : pin_c3});
      check(32'(c3s), str_m[1] ? 32'h0 : 32'(per.capcmp_unit_2));
      rdc(pa_pkg::ADDR_VALUE, val_exp());
      rdc(pa_pkg::ADDR_LATCH, lat_m);
      rdc(pa_pkg::ADDR_DIR, dir_m | 8'h08);
      rdc(pa_pkg::ADDR_STEER, str_m & 8'h69);
      check(rd14, {24'h000000, str_m & 8'h0A});
    end
    // Bit operations on input pins
    per <= '0;
    dir_m = 8'h3F;
    ana_m = 8'h00;
    mid <= 6'h00;
    load();
    for (int k = 0; k < 8; k++)
    begin
      r = rnd();
      ext <= r[13:8];
      repeat (6) @(posedge clk_sys);
      v = 8'h01 << (r[2:0] % 6);
      case (r[4:3] % 3)
        0: lat_m = val_exp() & ~v & 8'h37;
        1: lat_m = (val_exp() | v) & 8'h37;
        default: lat_m = (val_exp() ^ v) & 8'h37;
      endcase
      wr(pa_pkg::ADDR_BITOP, {3'h0, 2'(r[4:3] % 3), 3'(r[2:0] % 6)});
      rdc(pa_pkg::ADDR_LATCH, lat_m);
    end
    // Out-of-range index leaves the latch; op 3 stores the pin reads as they are
    wr(pa_pkg::ADDR_BITOP, 8'h0E);
    rdc(pa_pkg::ADDR_LATCH, lat_m);
    lat_m = val_exp() & 8'h37;
    wr(pa_pkg::ADDR_BITOP, 8'h19);
    rdc(pa_pkg::ADDR_LATCH, lat_m);
    // Steered input functions
    for (int s = 0; s < 4; s++)
    begin
      r = rnd();
      str_m = {4'h0, s[0], 2'h0, s[1]};
      load();
      ext <= r[5:0];
      repeat (6) @(posedge clk_sys);
      check({31'h0, t1g}, {31'h0, s[0] ? r[3] : r[4]});
      check({31'h0, cc1}, {31'h0, s[1] ? r[5] : r[2]});
    end
    complete_run();
  end
endmodule : tb

//--- src/pa_pkg.sv
// Shared constants and carrier types for the port A pin block
package pa_pkg;

  // ==========================================================================
  // Register byte addresses on the APB bus
  localparam logic [7:0] ADDR_VALUE = 8'h00;
  localparam logic [7:0] ADDR_DIR = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h08;
  localparam logic [7:0] ADDR_ODRAIN = 8'h0C;
  localparam logic [7:0] ADDR_SLEW = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  localparam logic [7:0] ADDR_ANALOG = 8'h18;
  localparam logic [7:0] ADDR_STEER = 8'h1C;
  localparam logic [7:0] ADDR_BITOP = 8'h20;

  // ==========================================================================
  // Implemented bit masks and reset values
  localparam logic [5:0] PIN_MASK = 6'h3F;
  localparam logic [5:0] OUT_MASK = 6'h37;
  localparam logic [5:0] ANA_MASK = 6'h17;
  localparam logic [5:0] DIR_RESET = 6'h3F;
  localparam logic [5:0] LATCH_RESET = 6'h00;
  localparam logic [5:0] ODRAIN_RESET = 6'h00;
  localparam logic [5:0] SLEW_RESET = 6'h37;
  localparam logic [5:0] THRESH_RESET = 6'h00;
  localparam logic [5:0] ANALOG_RESET = 6'h17;
  localparam logic [7:0] STEER_RESET = 8'h00;
  localparam logic [7:0] STEER_MASK_8PIN = 8'h69;
  localparam logic [7:0] STEER_MASK_14PIN = 8'h0A;
  localparam int INPUT_ONLY_PIN = 3;

  // ==========================================================================
  // Steering field positions
  localparam int WAVEGEN_A_PIN_SEL = 6;
  localparam int WAVEGEN_B_PIN_SEL = 5;
  localparam int TIMER1_GATE_PIN_SEL = 3;
  localparam int CAPCMP2_PIN_SEL = 1;
  localparam int CAPCMP1_PIN_SEL = 0;

  // ==========================================================================
  // Bit operation register fields
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_OP_LSB = 3;
  localparam logic [1:0] BITOP_CLEAR = 2'h0;
  localparam logic [1:0] BITOP_SET = 2'h1;
  localparam logic [1:0] BITOP_TOGGLE = 2'h2;

  // ==========================================================================
  // One peripheral output: enable (value override), value, direction override
  typedef struct packed {
    logic en;
    logic val;
    logic drv;
  } pa_src_t;

  // All peripheral outputs that may claim a port A pin
  typedef struct packed {
    pa_src_t dac;
    pa_src_t zcd;
    pa_src_t cmp1;
    pa_src_t clock_output_pin_fn;
    pa_src_t wg_a;
    pa_src_t wg_b;
    pa_src_t capcmp_unit_1;
    pa_src_t capcmp_unit_2;
  } pa_periph_t;

  // Pad controls for the six pins
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] slew;
    logic [5:0] schmitt;
    logic [5:0] analog;
  } pa_pad_t;

endpackage : pa_pkg

//--- src/pa_port_top.sv
// Port A general purpose I/O with alternate pin steering and APB registers
module pa_port_top #(
  parameter bit p_eight_pin = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [5:0] i_pin_st,
  input wire logic [5:0] i_pin_ttl,
  input wire logic i_pin_c3,
  input wire pa_pkg::pa_periph_t i_periph,
  output pa_pkg::pa_pad_t o_pad,
  output pa_pkg::pa_src_t o_c3_src,
  output logic [5:0] o_pin_digital,
  output logic o_timer1_gate_in,
  output logic o_capcmp1_in,
  output logic o_capcmp2_in
);

  // ==========================================================================
  // State
  logic [5:0] dir_q, dir_d;
  logic [5:0] lat_q, lat_d;
  logic [5:0] od_q, od_d;
  logic [5:0] slew_q, slew_d;
  logic [5:0] thr_q, thr_d;
  logic [5:0] ana_q, ana_d;
  logic [7:0] steer_q, steer_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [5:0] st_s1_q, st_s2_q, ttl_s1_q, ttl_s2_q;
  logic c3_s1_q, c3_s2_q;
  logic [5:0] din;
  logic [5:0] pin_val, pin_drv;
  pa_pkg::pa_pad_t pad_q, pad_d;
  pa_pkg::pa_src_t c3_q, c3_d;
  logic [5:0] pdig_q, pdig_d;
  logic gate_q, gate_d, cc1_q, cc1_d, cc2_q, cc2_d;
  logic acc_wr, acc_rd;
  logic [7:0] steer_mask;

  assign steer_mask = p_eight_pin ? pa_pkg::STEER_MASK_8PIN : pa_pkg::STEER_MASK_14PIN;

  // ==========================================================================
  // Address decode, shared by read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pa_pkg::ADDR_VALUE) || (a == pa_pkg::ADDR_DIR) ||
                 (a == pa_pkg::ADDR_LATCH) || (a == pa_pkg::ADDR_ODRAIN) ||
                 (a == pa_pkg::ADDR_SLEW) || (a == pa_pkg::ADDR_THRESH) ||
                 (a == pa_pkg::ADDR_ANALOG) || (a == pa_pkg::ADDR_STEER) ||
                 (a == pa_pkg::ADDR_BITOP);
  endfunction : addr_known

  // ==========================================================================
  // Output priority per pin; latch is the fallback (en low)
  function automatic pa_pkg::pa_src_t pin_pick(input int idx, input logic eight,
                                               input logic [7:0] st,
                                               input pa_pkg::pa_periph_t p,
                                               input logic lat);
    pa_pkg::pa_src_t r;
    r = '{en: 1'b0, val: lat, drv: 1'b0};
    unique case (idx)
      0:
      begin
        if (p.dac.en) r = p.dac;
        else if (eight && !st[pa_pkg::WAVEGEN_B_PIN_SEL] && p.wg_b.en) r = p.wg_b;
        else if (eight && p.capcmp_unit_2.en) r = p.capcmp_unit_2;
      end
      1:
      begin
        if (p.zcd.en) r = p.zcd;
      end
      2:
      begin
        if (eight && !st[pa_pkg::WAVEGEN_A_PIN_SEL] && p.wg_a.en) r = p.wg_a;
        else if (p.cmp1.en) r = p.cmp1;
        else if (eight && !st[pa_pkg::CAPCMP1_PIN_SEL] && p.capcmp_unit_1.en) r = p.capcmp_unit_1;
      end
      4:
      begin
        if (p.clock_output_pin_fn.en) r = p.clock_output_pin_fn;
        else if (eight && st[pa_pkg::WAVEGEN_B_PIN_SEL] && p.wg_b.en) r = p.wg_b;
      end
      5:
      begin
        if (eight && st[pa_pkg::WAVEGEN_A_PIN_SEL] && p.wg_a.en) r = p.wg_a;
        else if (eight && st[pa_pkg::CAPCMP1_PIN_SEL] && p.capcmp_unit_1.en) r = p.capcmp_unit_1;
        else if (!eight && st[pa_pkg::CAPCMP2_PIN_SEL] && p.capcmp_unit_2.en) r = p.capcmp_unit_2;
      end
      default:
      begin
        r = '{en: 1'b0, val: 1'b0, drv: 1'b0};
      end
    endcase
    pin_pick = r;
  endfunction : pin_pick

  // ==========================================================================
  // Pin input synchronisers
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_s1_q <= 6'h00;
      st_s2_q <= 6'h00;
      ttl_s1_q <= 6'h00;
      ttl_s2_q <= 6'h00;
      c3_s1_q <= 1'b0;
      c3_s2_q <= 1'b0;
    end
    else
    begin
      st_s1_q <= i_pin_st;
      st_s2_q <= st_s1_q;
      ttl_s1_q <= i_pin_ttl;
      ttl_s2_q <= ttl_s1_q;
      c3_s1_q <= i_pin_c3;
      c3_s2_q <= c3_s1_q;
    end
  end

  // Threshold pick then analog gating of the digital input path
  assign din = (thr_q & st_s2_q | ~thr_q & ttl_s2_q) & ~ana_q;

  // ==========================================================================
  // Per-pin source resolution
  for (genvar g = 0; g < 6; g++)
  begin : g_pin
    pa_pkg::pa_src_t w;
    assign w = pin_pick(g, p_eight_pin, steer_q, i_periph, lat_q[g]);
    assign pin_val[g] = w.val;
    // Direction or a peripheral override enables the driver, analog or not, on every pin but a3
    assign pin_drv[g] = (g != pa_pkg::INPUT_ONLY_PIN) && (!dir_q[g] || (w.en && w.drv));
  end

  // ==========================================================================
  // APB slave and register next state
  assign acc_wr = i_psel && i_penable && pready_q && i_pwrite && i_pstrb[0] &&
                  addr_known(i_paddr);
  assign acc_rd = i_psel && i_penable && !pready_q;

  always_comb
  begin
    logic [5:0] base;
    logic [2:0] idx;
    base = 6'h00;
    idx = 3'h0;
    dir_d = dir_q;
    lat_d = lat_q;
    od_d = od_q;
    slew_d = slew_q;
    thr_d = thr_q;
    ana_d = ana_q;
    steer_d = steer_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    // Access phase first cycle: prepare answer, one wait state
    if (acc_rd)
    begin
      pready_d = 1'b1;
      pslverr_d = !addr_known(i_paddr);
      prdata_d = 32'h0000_0000;
      if (!i_pwrite)
      begin
        unique case (i_paddr)
          pa_pkg::ADDR_VALUE: prdata_d[5:0] = din;
          pa_pkg::ADDR_DIR: prdata_d[5:0] = dir_q | 6'h08;
          pa_pkg::ADDR_LATCH: prdata_d[5:0] = lat_q & pa_pkg::OUT_MASK;
          pa_pkg::ADDR_ODRAIN: prdata_d[5:0] = od_q;
          pa_pkg::ADDR_SLEW: prdata_d[5:0] = slew_q;
          pa_pkg::ADDR_THRESH: prdata_d[5:0] = thr_q;
          pa_pkg::ADDR_ANALOG: prdata_d[5:0] = ana_q;
          pa_pkg::ADDR_STEER: prdata_d[7:0] = steer_q;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
    // Write takes effect at the edge that samples pready high
    if (acc_wr)
    begin
      unique case (i_paddr)
        pa_pkg::ADDR_VALUE, pa_pkg::ADDR_LATCH: lat_d = i_pwdata[5:0] & pa_pkg::OUT_MASK;
        pa_pkg::ADDR_DIR: dir_d = i_pwdata[5:0] | 6'h08;
        pa_pkg::ADDR_ODRAIN: od_d = i_pwdata[5:0] & pa_pkg::OUT_MASK;
        pa_pkg::ADDR_SLEW: slew_d = i_pwdata[5:0] & pa_pkg::OUT_MASK;
        pa_pkg::ADDR_THRESH: thr_d = i_pwdata[5:0] & pa_pkg::PIN_MASK;
        pa_pkg::ADDR_ANALOG: ana_d = i_pwdata[5:0] & pa_pkg::ANA_MASK;
        pa_pkg::ADDR_STEER: steer_d = i_pwdata[7:0] & steer_mask;
        pa_pkg::ADDR_BITOP:
        begin
          // Read pins, change one bit (op 3 changes none), store into the latch only for an index below 6
          base = din;
          idx = i_pwdata[pa_pkg::BITOP_IDX_LSB +: 3];
          if (idx < 3'h6)
          begin
            unique case (i_pwdata[pa_pkg::BITOP_OP_LSB +: 2])
              pa_pkg::BITOP_CLEAR: base[idx] = 1'b0;
              pa_pkg::BITOP_SET: base[idx] = 1'b1;
              pa_pkg::BITOP_TOGGLE: base[idx] = !base[idx];
              default: base = base;
            endcase
            lat_d = base & pa_pkg::OUT_MASK;
          end
        end
        default: lat_d = lat_q;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dir_q <= pa_pkg::DIR_RESET;
      lat_q <= pa_pkg::LATCH_RESET;
      od_q <= pa_pkg::ODRAIN_RESET;
      slew_q <= pa_pkg::SLEW_RESET;
      thr_q <= pa_pkg::THRESH_RESET;
      ana_q <= pa_pkg::ANALOG_RESET;
      steer_q <= pa_pkg::STEER_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      dir_q <= dir_d;
      lat_q <= lat_d;
      od_q <= od_d;
      slew_q <= slew_d;
      thr_q <= thr_d;
      ana_q <= ana_d;
      steer_q <= steer_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================================
  // Pad and steered-input next values
  always_comb
  begin
    pad_d.out = od_q & 6'h00 | ~od_q & pin_val;
    pad_d.oe = pin_drv & (~od_q | ~pin_val);
    pad_d.slew = slew_q;
    pad_d.schmitt = thr_q;
    pad_d.analog = ana_q;
    pdig_d = din;
    gate_d = steer_q[pa_pkg::TIMER1_GATE_PIN_SEL] ? din[3] : din[4];
    cc1_d = (p_eight_pin && steer_q[pa_pkg::CAPCMP1_PIN_SEL]) ? din[5] : din[2];
    c3_d = '{en: 1'b0, val: 1'b0, drv: 1'b0};
    if (p_eight_pin)
      cc2_d = din[0];
    else if (steer_q[pa_pkg::CAPCMP2_PIN_SEL])
      cc2_d = din[5];
    else
    begin
      cc2_d = c3_s2_q;
      c3_d = i_periph.capcmp_unit_2;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pad_q <= '{out: 6'h00, oe: 6'h00, slew: pa_pkg::SLEW_RESET,
                 schmitt: pa_pkg::THRESH_RESET, analog: pa_pkg::ANALOG_RESET};
      c3_q <= '{en: 1'b0, val: 1'b0, drv: 1'b0};
      pdig_q <= 6'h00;
      gate_q <= 1'b0;
      cc1_q <= 1'b0;
      cc2_q <= 1'b0;
    end
    else
    begin
      pad_q <= pad_d;
      c3_q <= c3_d;
      pdig_q <= pdig_d;
      gate_q <= gate_d;
      cc1_q <= cc1_d;
      cc2_q <= cc2_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_pad = pad_q;
  assign o_c3_src = c3_q;
  assign o_pin_digital = pdig_q;
  assign o_timer1_gate_in = gate_q;
  assign o_capcmp1_in = cc1_q;
  assign o_capcmp2_in = cc2_q;

  // ==========================================================================
  // Assertions and covers
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_input_only_pin: assert property (!o_pad.oe[3])
    else $error("input-only pin a3 driven");
  a_dir_reads_one: assert property (pready_q && !i_pwrite && i_paddr == pa_pkg::ADDR_DIR
                                    |-> prdata_q[3])
    else $error("direction bit 3 read as zero");
  a_dir_off_pin1: assert property ($past(dir_q[1] && !(i_periph.zcd.en && i_periph.zcd.drv))
                                   |-> !o_pad.oe[1])
    else $error("pin a1 driven while direction is input");
  a_latch_drives: assert property ($past(!dir_q[1] && !i_periph.zcd.en && !od_q[1])
                                   |-> o_pad.oe[1] && o_pad.out[1] == $past(lat_q[1]))
    else $error("latch value not on pin a1");
  a_open_drain_sink: assert property ((o_pad.oe & o_pad.out & $past(od_q)) == 6'h00)
    else $error("open-drain pin driven high");
  a_slew_follows: assert property (o_pad.slew == $past(slew_q))
    else $error("slew control not on pad");
  a_analog_zero: assert property (pready_q && !i_pwrite && i_paddr == pa_pkg::ADDR_VALUE
                                  |-> (prdata_q[5:0] & $past(ana_q)) == 6'h00)
    else $error("analog pin read as one");
  a_latch_readback: assert property (pready_q && !i_pwrite && i_paddr == pa_pkg::ADDR_LATCH
                                     |-> prdata_q[5:0] == (lat_q & pa_pkg::OUT_MASK))
    else $error("latch read does not return latch");
  a_gate_steer: assert property (o_timer1_gate_in ==
                                 $past(steer_q[3] ? din[3] : din[4]))
    else $error("timer1 gate taken from wrong pin");
  a_wavegen_a_alt: assert property (p_eight_pin && $past(steer_q[6] && i_periph.wg_a.en && !od_q[5])
                                    |-> o_pad.out[5] == $past(i_periph.wg_a.val))
    else $error("wavegen A not on pin a5");
  a_dac_priority: assert property ($past(i_periph.dac.en && !od_q[0])
                                   |-> o_pad.out[0] == $past(i_periph.dac.val))
    else $error("dac output lost priority on a0");
  a_wait_state: assert property (i_psel && i_penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("answer not after one wait state");

  c_value_write: cover property (acc_wr && i_paddr == pa_pkg::ADDR_VALUE);
  c_bit_op: cover property (acc_wr && i_paddr == pa_pkg::ADDR_BITOP);
  c_steer_alt: cover property (steer_q[pa_pkg::WAVEGEN_A_PIN_SEL] && i_periph.wg_a.en);
  c_unmapped: cover property (pready_q && pslverr_q);

endmodule : pa_port_top
